// File: include/pfc_pkg.sv
// shared constants and types for the parallel flash configuration controller
package pfc_pkg;

   // timing
   localparam int PFC_CLK_PERIOD_NS = 10;
   localparam int PFC_PROG_MIN_NS = 300;
   localparam int PFC_PROG_MIN_CYCLES = (PFC_PROG_MIN_NS + PFC_CLK_PERIOD_NS - 1) /
      PFC_CLK_PERIOD_NS;
   localparam int PFC_CLEAR_CYCLES_DEF = 64;

   // flash side widths and addresses
   localparam int PFC_ADDR_W = 24;
   localparam int PFC_DATA_W = 8;
   localparam logic [23:0] PFC_ADDR_BOTTOM = 24'h000000;
   localparam logic [23:0] PFC_ADDR_TOP = 24'h0fffff;
   localparam logic [23:0] PFC_ADDR_STEP = 24'h000001;

   // configuration stream layout
   localparam int PFC_CFG_BYTES_DEF = 64;
   localparam logic [7:0] PFC_CRC_POLY = 8'h07;
   localparam logic [7:0] PFC_CRC_INIT = 8'h00;

   // config clock half periods in pclk cycles, slowest first
   localparam int PFC_HALF_W = 8;
   localparam logic [7:0] PFC_HALF_RATE0 = 8'h20;
   localparam logic [7:0] PFC_HALF_RATE1 = 8'h10;
   localparam logic [7:0] PFC_HALF_RATE2 = 8'h08;
   localparam logic [7:0] PFC_HALF_RATE3 = 8'h04;

   // apb register byte offsets
   localparam logic [7:0] PFC_OFS_CTRL = 8'h00;
   localparam logic [7:0] PFC_OFS_CHAIN_LEN = 8'h04;
   localparam logic [7:0] PFC_OFS_STATUS = 8'h08;
   localparam logic [7:0] PFC_OFS_ADDR = 8'h0c;
   localparam logic [7:0] PFC_OFS_DATA = 8'h10;

   // ctrl fields
   localparam int PFC_CTRL_SOFT_PROG_BIT = 0;
   localparam int PFC_CTRL_CHAIN_EN_BIT = 1;
   localparam logic [23:0] PFC_CHAIN_LEN_RESET = 24'h000010;

   typedef enum logic [2:0] {
      PFC_ST_HOLD,
      PFC_ST_CLEAR,
      PFC_ST_LOAD,
      PFC_ST_CHAIN,
      PFC_ST_DONE,
      PFC_ST_ERROR
   } pfc_state_type;

   function automatic logic [7:0] pfc_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ((c << 1) ^ PFC_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : pfc_crc8

   function automatic logic [7:0] pfc_half_for_rate(input logic [1:0] rate);
      logic [7:0] h;
      h = PFC_HALF_RATE0;
      case (rate)
         2'h1: h = PFC_HALF_RATE1;
         2'h2: h = PFC_HALF_RATE2;
         2'h3: h = PFC_HALF_RATE3;
         default: h = PFC_HALF_RATE0;
      endcase
      return h;
   endfunction : pfc_half_for_rate

endpackage : pfc_pkg

// File: rtl/pfc_clk_gen.sv
// config clock divider with edge strobes
`timescale 1ns/10ps
module pfc_clk_gen
   import pfc_pkg::*;
#(
   parameter int HALF_W = PFC_HALF_W
)
(
   // system
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic [HALF_W-1:0] half_period,
   // clock and strobes
   output logic clk_level,
   output logic rise_pulse,
   output logic fall_pulse
);

   logic [HALF_W-1:0] cnt_reg;
   logic at_end;

   // half period is compared every cycle, so a rate change can cut short the phase in progress
   assign at_end = (cnt_reg + HALF_W'(1)) >= half_period;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_reg <= '0;
      else if (!run || at_end)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + HALF_W'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_level <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end
      else
      begin
         rise_pulse <= run && at_end && !clk_level;
         fall_pulse <= run && at_end && clk_level;
         if (run && at_end)
            clk_level <= !clk_level;
      end
   end

endmodule : pfc_clk_gen

// File: rtl/pfc_config_ctrl.sv
// parallel flash configuration master: control, status and flash pins
//
// Overview of operation
// - accept one flash byte per address
// - chain select low only while selecting downstream
// - busy output always actively driven; busy_oe is low in hold and during reset
// - drive config clock continuously while configuring
// - init pulled low while memory clears
// - release init, sample mode at that moment
// - crc mismatch pulls init low
// - done low until successful completion
// - program low 300 ns restarts configuration
// - reset indicators when program returns high
// - program low puts flash pins hi-z
// - new flash address on falling edge
// - direction select picks up or down sequence
// - write enable held high while configuring
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module pfc_config_ctrl
   import pfc_pkg::*;
#(
   parameter int CFG_BYTES = PFC_CFG_BYTES_DEF,
   parameter int CLEAR_CYCLES = PFC_CLEAR_CYCLES_DEF
)
(
   // system and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash interface
   output logic [PFC_ADDR_W-1:0] flash_addr,
   input wire logic [PFC_DATA_W-1:0] flash_data_in,
   output logic flash_chip_enable_n,
   output logic flash_output_enable_n,
   output logic flash_write_enable_n,
   output logic flash_pins_oe,
   // clock and chain
   output logic config_clock,
   output logic config_clock_oe,
   output logic chain_select_out_n,
   output logic chain_select_oe,
   output logic busy_out,
   output logic busy_oe,
   // open-drain indicators and control pins
   input wire logic init_in,
   output logic init_out,
   output logic init_oe,
   output logic done_out,
   output logic done_oe,
   input wire logic program_request_n,
   input wire logic address_direction_select
);

   localparam int SYNC_W = PFC_DATA_W + 3;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] LAST_BYTE = CNT_W'(CFG_BYTES - 1);
   localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);
   localparam logic [9:0] PROG_LAST = 10'(PFC_PROG_MIN_CYCLES - 1);

   // pin synchronisers
   logic [SYNC_W-1:0] async_in, sync1_reg, sync2_reg;
   logic [PFC_DATA_W-1:0] data_sync;
   logic prog_n_sync, dir_sync, init_sync;

   assign async_in = {address_direction_select, program_request_n, init_in, flash_data_in};

   generate
      for (genvar i = 0; i < SYNC_W; i++)
      begin : g_sync
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sync1_reg[i] <= 1'b1;
               sync2_reg[i] <= 1'b1;
            end
            else
            begin
               sync1_reg[i] <= async_in[i];
               sync2_reg[i] <= sync1_reg[i];
            end
         end
      end
   endgenerate

   assign {dir_sync, prog_n_sync, init_sync, data_sync} = sync2_reg;

   // state and registers
   pfc_state_type state_reg;
   logic [9:0] prog_cnt_reg;
   logic [CNT_W-1:0] chain_len_reg, byte_cnt_reg, chain_cnt_reg;
   logic [15:0] clear_cnt_reg;
   logic [PFC_DATA_W-1:0] last_byte_reg;
   logic [7:0] crc_reg;
   logic [1:0] rate_reg;
   logic [PFC_ADDR_W-1:0] addr_reg;
   logic prog_hit, soft_prog_reg, chain_en_reg, dir_down_reg, step_pending_reg, crc_err_reg;
   logic config_clock_level, config_clock_rise, config_clock_fall, clear_end, loading;

   assign clear_end = (state_reg == PFC_ST_CLEAR) && (clear_cnt_reg == CLEAR_LAST);
   assign loading = (state_reg == PFC_ST_LOAD) || (state_reg == PFC_ST_CHAIN);

   // a pulse shorter than the minimum never saturates the counter and is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prog_cnt_reg <= '0;
      else if (prog_n_sync)
         prog_cnt_reg <= '0;
      else if (prog_cnt_reg != PROG_LAST)
         prog_cnt_reg <= prog_cnt_reg + 10'h001;
   end

   assign prog_hit = (!prog_n_sync && (prog_cnt_reg == PROG_LAST)) || soft_prog_reg;

   // main sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= PFC_ST_CLEAR;
      else if (prog_hit)
         state_reg <= PFC_ST_HOLD;
      else
      begin
         case (state_reg)
            PFC_ST_HOLD:
               if (prog_n_sync)
                  state_reg <= PFC_ST_CLEAR;
            PFC_ST_CLEAR:
               if (clear_end)
                  state_reg <= PFC_ST_LOAD;
            PFC_ST_LOAD:
               if (config_clock_rise && byte_cnt_reg == LAST_BYTE)
               begin
                  if (crc_reg != data_sync)
                     state_reg <= PFC_ST_ERROR;
                  else if (chain_en_reg && chain_len_reg != '0)
                     state_reg <= PFC_ST_CHAIN;
                  else
                     state_reg <= PFC_ST_DONE;
               end
            PFC_ST_CHAIN:
               if (config_clock_rise && chain_cnt_reg + CNT_W'(1) >= chain_len_reg)
                  state_reg <= PFC_ST_DONE;
            PFC_ST_DONE, PFC_ST_ERROR: state_reg <= state_reg;
            default: state_reg <= PFC_ST_CLEAR;
         endcase
      end
   end

   // memory clear timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clear_cnt_reg <= '0;
      else if (state_reg != PFC_ST_CLEAR)
         clear_cnt_reg <= '0;
      else if (!clear_end)
         clear_cnt_reg <= clear_cnt_reg + 16'h0001;
   end

   // mode captured in the same cycle init is let go
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_down_reg <= 1'b0;
      else if (clear_end)
         dir_down_reg <= dir_sync;
   end

   // byte capture, crc and rate byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         byte_cnt_reg <= '0;
         last_byte_reg <= '0;
         crc_reg <= PFC_CRC_INIT;
         rate_reg <= 2'h0;
         crc_err_reg <= 1'b0;
      end
      else if (state_reg == PFC_ST_CLEAR)
      begin
         byte_cnt_reg <= '0;
         crc_reg <= PFC_CRC_INIT;
         rate_reg <= 2'h0;
         crc_err_reg <= 1'b0;
      end
      else if (state_reg == PFC_ST_LOAD && config_clock_rise)
      begin
         last_byte_reg <= data_sync;
         byte_cnt_reg <= byte_cnt_reg + CNT_W'(1);
         if (byte_cnt_reg == '0)
            rate_reg <= data_sync[1:0];
         if (byte_cnt_reg == LAST_BYTE)
            crc_err_reg <= crc_reg != data_sync;
         else
            crc_reg <= pfc_crc8(crc_reg, data_sync);
      end
   end

   // bytes clocked out for downstream devices
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         chain_cnt_reg <= '0;
      else if (state_reg != PFC_ST_CHAIN)
         chain_cnt_reg <= '0;
      else if (config_clock_rise)
         chain_cnt_reg <= chain_cnt_reg + CNT_W'(1);
   end

   // address steps only on the falling edge, half a period before the next capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         step_pending_reg <= 1'b0;
      else if (!loading)
         step_pending_reg <= 1'b0;
      else if (config_clock_rise)
         step_pending_reg <= 1'b1;
      else if (config_clock_fall)
         step_pending_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         addr_reg <= PFC_ADDR_BOTTOM;
      else if (clear_end)
         addr_reg <= dir_sync ? PFC_ADDR_TOP : PFC_ADDR_BOTTOM;
      else if (loading && config_clock_fall && step_pending_reg)
         addr_reg <= dir_down_reg ? addr_reg - PFC_ADDR_STEP : addr_reg + PFC_ADDR_STEP;
   end

   // config clock keeps running after done so chained parts can finish
   pfc_clk_gen #(
      .HALF_W(PFC_HALF_W)
   ) u_clk_gen (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_reg != PFC_ST_HOLD),
      .half_period(pfc_half_for_rate(rate_reg)),
      .clk_level(config_clock_level),
      .rise_pulse(config_clock_rise),
      .fall_pulse(config_clock_fall)
   );

   // pin drivers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_addr <= PFC_ADDR_BOTTOM;
         flash_chip_enable_n <= 1'b1;
         flash_output_enable_n <= 1'b1;
         flash_write_enable_n <= 1'b1;
         flash_pins_oe <= 1'b0;
         config_clock <= 1'b0;
         config_clock_oe <= 1'b0;
         chain_select_out_n <= 1'b1;
         chain_select_oe <= 1'b0;
         busy_out <= 1'b0;
         busy_oe <= 1'b0;
         init_out <= 1'b0;
         init_oe <= 1'b1;
         done_out <= 1'b0;
         done_oe <= 1'b1;
      end
      else
      begin
         flash_addr <= addr_reg;
         flash_chip_enable_n <= !loading;
         flash_output_enable_n <= !loading;
         flash_write_enable_n <= 1'b1;
         flash_pins_oe <= state_reg != PFC_ST_HOLD;
         config_clock <= config_clock_level;
         config_clock_oe <= state_reg != PFC_ST_HOLD;
         chain_select_out_n <= state_reg != PFC_ST_CHAIN;
         chain_select_oe <= state_reg != PFC_ST_HOLD;
         busy_out <= 1'b0;
         busy_oe <= state_reg != PFC_ST_HOLD;
         // open-drain indicators: output value fixed low, enable pulls
         init_out <= 1'b0;
         init_oe <= (state_reg == PFC_ST_CLEAR && !clear_end) ||
            state_reg == PFC_ST_ERROR;
         done_out <= 1'b0;
         done_oe <= state_reg != PFC_ST_DONE;
      end
   end

   // apb slave: one wait state so read data comes from a flop
   logic access, wr_take, addr_ok;
   logic [31:0] rd_mux;

   assign access = psel && penable;
   assign wr_take = access && pready && pwrite && !pslverr;
   assign addr_ok = paddr == PFC_OFS_CTRL || paddr == PFC_OFS_CHAIN_LEN ||
      paddr == PFC_OFS_STATUS || paddr == PFC_OFS_ADDR || paddr == PFC_OFS_DATA;

   always_comb
   begin
      rd_mux = 32'h00000000;
      case (paddr)
         PFC_OFS_CTRL: rd_mux = {30'h00000000, chain_en_reg, 1'b0};
         PFC_OFS_CHAIN_LEN: rd_mux = {8'h00, chain_len_reg};
         PFC_OFS_STATUS: rd_mux = {22'h000000, rate_reg, dir_down_reg, init_sync, prog_n_sync,
            crc_err_reg, state_reg == PFC_ST_DONE, state_reg};
         PFC_OFS_ADDR: rd_mux = {8'h00, addr_reg};
         PFC_OFS_DATA: rd_mux = {last_byte_reg, byte_cnt_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= access && !pready;
         pslverr <= access && !pready && !addr_ok;
         prdata <= (access && !pready && !pwrite && addr_ok) ? rd_mux : 32'h00000000;
      end
   end

   // software control bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         soft_prog_reg <= 1'b0;
         chain_en_reg <= 1'b0;
         chain_len_reg <= PFC_CHAIN_LEN_RESET;
      end
      else
      begin
         soft_prog_reg <= wr_take && paddr == PFC_OFS_CTRL &&
            pwdata[PFC_CTRL_SOFT_PROG_BIT];
         if (wr_take && paddr == PFC_OFS_CTRL)
            chain_en_reg <= pwdata[PFC_CTRL_CHAIN_EN_BIT];
         if (wr_take && paddr == PFC_OFS_CHAIN_LEN)
            chain_len_reg <= pwdata[CNT_W-1:0];
      end
   end

endmodule : pfc_config_ctrl

// File: dv/pfc_config_ctrl_props.sv
// concurrent checks on the configuration controller pins
`timescale 1ns/10ps
module pfc_config_ctrl_props
   import pfc_pkg::*;
#(
   parameter int CLEAR_CYCLES = PFC_CLEAR_CYCLES_DEF
)
(
   // system and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // flash and pins
   input wire logic [PFC_ADDR_W-1:0] flash_addr,
   input wire logic flash_chip_enable_n,
   input wire logic flash_output_enable_n,
   input wire logic flash_write_enable_n,
   input wire logic flash_pins_oe,
   input wire logic config_clock,
   input wire logic config_clock_oe,
   input wire logic chain_select_out_n,
   input wire logic chain_select_oe,
   input wire logic busy_out,
   input wire logic busy_oe,
   input wire logic init_oe,
   input wire logic done_oe,
   input wire logic program_request_n
);
   logic [7:0] low_cnt;
   logic [7:0] init_cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // saturating counts, long holds cannot be written as repetitions
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) low_cnt <= 8'h00;
      else if (program_request_n) low_cnt <= 8'h00;
      else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) init_cnt <= 8'h00;
      else if (!init_oe) init_cnt <= 8'h00;
      else if (init_cnt != 8'hff) init_cnt <= init_cnt + 8'h01;

   a_write_off: assert property (flash_write_enable_n)
      else $error("flash write enable went low");
   a_chain_only: assert property (!chain_select_out_n |-> chain_select_oe && done_oe)
      else $error("chain select low outside chaining");
   a_busy_driven: assert property (config_clock_oe |-> busy_oe && !busy_out)
      else $error("busy pin not driven");
   a_clock_runs: assert property (config_clock_oe && program_request_n
      |-> ##[1:34] ($changed(config_clock) || !config_clock_oe))
      else $error("config clock stalled");
   a_prog_hiz: assert property (low_cnt >= 8'h28 |-> !flash_pins_oe && !config_clock_oe)
      else $error("pins driven while program held");
   a_clear_len: assert property ($fell(init_oe) |-> init_cnt >= CLEAR_CYCLES - 1)
      else $error("init released too early");
   a_done_clean: assert property (!done_oe |-> !init_oe)
      else $error("done released with init low");
   a_addr_fall: assert property ($changed(flash_addr) && !init_oe && !$past(init_oe)
      && !$past(init_oe, 2) && $past(flash_pins_oe)
      |-> !config_clock && !$past(config_clock) && $past(config_clock, 2))
      else $error("address moved off a falling edge");
   a_enables_low: assert property (!init_oe && done_oe && config_clock_oe && !$past(init_oe)
      && $past(done_oe) |-> !flash_chip_enable_n && !flash_output_enable_n)
      else $error("flash enables high while loading");
   a_apb_answer: assert property ($rose(penable) && psel |=> pready)
      else $error("apb answer late");
   a_bad_addr: assert property (pready && paddr > 8'h10 |-> pslverr)
      else $error("unmapped access not refused");
endmodule : pfc_config_ctrl_props

bind pfc_config_ctrl pfc_config_ctrl_props #(.CLEAR_CYCLES(CLEAR_CYCLES)) i_props (.pclk,
   .presetn, .psel, .penable, .paddr, .pready, .pslverr, .flash_addr, .flash_chip_enable_n,
   .flash_output_enable_n, .flash_write_enable_n, .flash_pins_oe, .config_clock,
   .config_clock_oe, .chain_select_out_n, .chain_select_oe, .busy_out, .busy_oe, .init_oe,
   .done_oe, .program_request_n);

// File: dv/pfc_flash_model.sv
// behavioural byte-wide flash and downstream chained device
`timescale 1ns/10ps
module pfc_flash_model
   import pfc_pkg::*;
(
   // flash pins
   input wire logic [PFC_ADDR_W-1:0] flash_addr,
   input wire logic flash_chip_enable_n,
   input wire logic flash_output_enable_n,
   input wire logic flash_pins_oe,
   input wire logic slow,
   output logic [PFC_DATA_W-1:0] flash_data,
   // downstream device
   input wire logic config_clock,
   input wire logic chain_select_out_n,
   output int chain_bytes
);
   logic [7:0] mem [int];
   initial flash_data = 8'h5a;
   initial chain_bytes = 0;

   // during an access or when deselected the bus shows a flipped pattern, never the old byte
   always @(flash_addr, flash_chip_enable_n, flash_output_enable_n, flash_pins_oe)
   begin
      flash_data = ~flash_data;
      #(slow ? 8 : 2);
      if (!flash_chip_enable_n && !flash_output_enable_n && flash_pins_oe)
         flash_data = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hff;
   end

   // chain select is the downstream chip select
   always @(posedge config_clock)
      if (chain_select_out_n === 1'b0)
         chain_bytes++;
endmodule : pfc_flash_model

// File: dv/tb.sv
// self-checking bench for the parallel flash configuration controller
`timescale 1ns/10ps
module tb;
   import pfc_pkg::*;
   localparam int N_BYTES = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] flash_addr;
   logic [7:0] flash_data_in;
   logic flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n, flash_pins_oe;
   logic config_clock, config_clock_oe, chain_select_out_n, chain_select_oe, busy_out, busy_oe;
   logic init_in, init_out, init_oe, done_out, done_oe;
   logic program_request_n, address_direction_select;
   logic [7:0] img [N_BYTES];
   logic [2:0] st;
   int chain_bytes, n_mismatch, checked, seed, base;

   // init pin has a pull-up; nothing else pulls it once loading is over
   assign init_in = init_oe ? init_out : 1'b1;

   pfc_config_ctrl #(.CFG_BYTES(N_BYTES), .CLEAR_CYCLES(8)) i_pfc_config_ctrl (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
      .flash_data_in, .flash_chip_enable_n, .flash_output_enable_n, .flash_write_enable_n,
      .flash_pins_oe, .config_clock, .config_clock_oe, .chain_select_out_n, .chain_select_oe,
      .busy_out, .busy_oe, .init_in, .init_out, .init_oe, .done_out, .done_oe,
      .program_request_n, .address_direction_select);
   pfc_flash_model i_pfc_flash_model (.flash_addr, .flash_chip_enable_n, .flash_output_enable_n,
      .flash_pins_oe, .slow, .flash_data(flash_data_in), .config_clock, .chain_select_out_n,
      .chain_bytes);

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      repeat (8) x = {x[6:0], 1'b0} ^ (x[7] ? PFC_CRC_POLY : 8'h00);
      return x;
   endfunction : crc_step

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk(n < 20, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // image: byte 0 carries the rate, last byte the check value, bit 0 flipped if bad
   task fill(input logic [1:0] rate, input logic dir, input logic bad);
      logic [7:0] c;
      c = PFC_CRC_INIT;
      for (int i = 0; i < N_BYTES; i++)
      begin
         img[i] = 8'($random(seed));
         if (i == 0) img[0][1:0] = rate;
         if (i == N_BYTES - 1) img[i] = c ^ {7'h00, bad};
         c = crc_step(c, img[i]);
         i_pfc_flash_model.mem[dir ? int'(PFC_ADDR_TOP) - i : i] = img[i];
      end
      address_direction_select <= dir;
   endtask : fill

   task pulse(input int low);
      @(posedge pclk);
      program_request_n <= 1'b0;
      repeat (low) @(posedge pclk);
      if (low > 40)
      begin
         chk(flash_pins_oe, 1'b0);
         chk(config_clock_oe, 1'b0);
      end
      program_request_n <= 1'b1;
   endtask : pulse

   task expect_load(input logic [1:0] rate, input logic dir, input logic bad, input logic chain);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, PFC_OFS_STATUS, 32'h0);
         st = rd[2:0];
         k++;
      end
      while (st !== PFC_ST_DONE && st !== PFC_ST_ERROR && k < 400);
      chk(st, bad ? PFC_ST_ERROR : PFC_ST_DONE);
      chk(rd[9:8], rate);
      chk(rd[7], dir);
      chk(init_oe, bad);
      chk(done_oe, bad);
      chk(busy_out, 1'b0);
      chk(flash_write_enable_n, 1'b1);
      apb(1'b0, PFC_OFS_DATA, 32'h0);
      chk(rd[23:0], N_BYTES);
      if (!chain) chk(rd[31:24], img[N_BYTES-1]);
      if (!chain)
         chk(flash_addr, dir ? PFC_ADDR_TOP - 24'(N_BYTES-1) : 24'(N_BYTES-1));
      $display("load test done rate %0d dir %0d bad %0d", rate, dir, bad);
   endtask : expect_load

   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   initial
   begin
      #500000;
      n_mismatch++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run;
   end

   initial
   begin
      seed = 57;
      n_mismatch = 0;
      checked = 0;
      {psel, penable, pwrite, paddr, pwdata, slow, presetn} = '0;
      program_request_n = 1'b1;
      address_direction_select = 1'b0;
      fill(2'h3, 1'b0, 1'b0);
      repeat (10) @(posedge pclk);
      chk(init_oe, 1'b1);
      chk(done_oe, 1'b1);
      presetn <= 1'b1;
      apb(1'b0, PFC_OFS_CHAIN_LEN, 32'h0);
      chk(rd, PFC_CHAIN_LEN_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      expect_load(2'h3, 1'b0, 1'b0, 1'b0);
      // every rate, both directions, one corrupt image, slow flash on the upper rates
      for (int r = 0; r < 4; r++)
      begin
         slow <= r[1];
         fill(r[1:0], r[0], r == 1);
         pulse(45);
         expect_load(r[1:0], r[0], r == 1, 1'b0);
      end
      pulse(10);
      apb(1'b0, PFC_OFS_STATUS, 32'h0);
      chk(rd[2:0], PFC_ST_DONE);
      chk(done_oe, 1'b0);
      $display("short pulse test done");
      apb(1'b1, PFC_OFS_CHAIN_LEN, 32'h3);
      fill(2'h2, 1'b0, 1'b0);
      base = chain_bytes;
      apb(1'b1, PFC_OFS_CTRL, 32'h3);
      expect_load(2'h2, 1'b0, 1'b0, 1'b1);
      chk(chain_bytes - base, 3);
      chk(chain_select_out_n, 1'b1);
      $display("chain test done");
      complete_run;
   end
endmodule : tb
